// ===== inc/shr_afi_if.sv
/*
 * Controller-to-PHY connection with one modport per end.
 * Assumes both ends share clk; no clocking block, the testbench samples directly.
 */
`timescale 1ns/1ps
interface shr_afi_if import shr_pkg::*; ();

    // ------------------------------------------------------------------
    // Command and address
    // ------------------------------------------------------------------
    logic cmd_valid;                   // One-cycle memory command strobe.
    logic cmd_wr;                      // High for write, low for read.
    logic [BANK_W-1:0] bank;           // Memory bank.
    logic [ROW_W-1:0] row;             // Memory row.
    logic [MCOL_W-1:0] col;            // Memory column (already shifted).

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    logic [DW-1:0] wdata;              // Write data beat.
    logic [BE_W-1:0] dm;               // Write masks, high means byte masked.
    logic wdata_valid;                 // Data and masks valid.
    logic dqs_burst;                   // Strobe burst window.

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic doing_rd;                    // One cycle per expected read word.
    logic [DW-1:0] rdata;              // Returned read data.
    logic rdata_valid;                 // Read data valid.

    modport ctrl (
        output cmd_valid, cmd_wr, bank, row, col, wdata, dm, wdata_valid, dqs_burst,
        output doing_rd,
        input rdata, rdata_valid
    );

    modport phy (
        input cmd_valid, cmd_wr, bank, row, col, wdata, dm, wdata_valid, dqs_burst,
        input doing_rd,
        output rdata, rdata_valid
    );

endinterface

// ===== inc/shr_pkg.sv
/*
 * Shared constants for the half-rate request path of the SDRAM controller.
 * Assumes a single controller clock domain shared by controller and PHY end.
 */
package shr_pkg;

    // ------------------------------------------------------------------
    // Address and data widths
    // ------------------------------------------------------------------
    localparam int COL_W = 8;          // Local column width.
    localparam int COL_SHIFT = 2;      // Half-rate local-to-memory column shift.
    localparam int MCOL_W = COL_W + COL_SHIFT; // Memory column width.
    localparam int ROW_W = 13;         // Row width.
    localparam int BANK_W = 3;         // Bank width.
    localparam int SIZE_W = 2;         // Local transfer size width (1 or 2 beats).
    localparam int DW = 32;            // Local and PHY data width per clock.
    localparam int BE_W = DW / 8;      // Byte enables per word.

    // ------------------------------------------------------------------
    // Depths and latencies
    // ------------------------------------------------------------------
    localparam int CMDQ_DEPTH = 4;     // Command queue entries (power of two).
    localparam int ECC_LAT_DEF = 0;    // Read return delay: 0 without ECC, 1 or 3 with.
    localparam int RESYNC_STAGES = 2;  // PHY read resynchronisation stages.

    // ------------------------------------------------------------------
    // Issue state machine, Gray coded along idle -> command -> transfer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SHR_IDLE = 2'h0,
        SHR_CMD = 2'h1,
        SHR_XFER = 2'h3
    } shr_state_t;

endpackage

// ===== rtl/shr_ctrl.sv
/*
 * Controller end: local request acceptance, queueing, half-rate address
 * mapping, write split and merge, PHY command/data and read return.
 * Assumes the PHY end returns read words in order of issue.
 */
// Functional notes
// [R01] User starts read with request, size, address.
// [R02] Request with ready high is accepted.
// [R03] Held write stays stable until ready high.
// [R04] Ready drops when command queue full.
// [R05] Held read stays stable until ready high.
// [R06] Memory column is local column shifted two.
// [R07] Each accepted request issues memory command.
// [R08] Write-valid marks exactly driven data and masks.
// [R09] Strobe burst spans write data toggling.
// [R10] Doing-read high one cycle per read word.
// [R11] PHY captures while doing-read window open.
// [R12] PHY sends read command, captures data.
// [R13] PHY resyncs and returns data with valid.
// [R14] Read return delayed zero, one or three.
// [R15] PHY sends write command, data, strobe.
// [R16] Non-aligned write split into further burst.
// [R17] Size-two write: two accepted cycles.
// [R18] Sequential writes same row/bank merge.
// [R19] Reads return in acceptance order.
`timescale 1ns/1ps
module shr_ctrl import shr_pkg::*; #(
    parameter int DEPTH = CMDQ_DEPTH,
    parameter int ECC_LAT = ECC_LAT_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Local request side
    input wire logic local_read_req,
    input wire logic local_write_req,
    input wire logic [SIZE_W-1:0] local_size,
    input wire logic [BANK_W-1:0] local_bank,
    input wire logic [ROW_W-1:0] local_row,
    input wire logic [COL_W-1:0] local_col,
    input wire logic [DW-1:0] local_wdata,
    input wire logic [BE_W-1:0] local_be,
    output logic local_ready,
    // Local read return
    output logic [DW-1:0] local_rdata,
    output logic local_rdata_valid,
    // PHY side
    shr_afi_if.ctrl afi
);

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // Command queue storage
    // ------------------------------------------------------------------
    logic q_wr [DEPTH];                // Entry is a write beat.
    logic [BANK_W-1:0] q_bank [DEPTH]; // Bank of entry.
    logic [ROW_W-1:0] q_row [DEPTH];   // Row of entry.
    logic [COL_W-1:0] q_col [DEPTH];   // Local column of entry.
    logic [SIZE_W-1:0] q_size [DEPTH]; // Read size; writes hold one beat.
    logic [DW-1:0] q_data [DEPTH];     // Write data beat.
    logic [BE_W-1:0] q_be [DEPTH];     // Write byte enables.
    logic [PW-1:0] wr_ptr_reg;         // Next free entry.
    logic [PW-1:0] rd_ptr_reg;         // Oldest entry.
    logic [PW:0] count_reg;            // Entries held.
    logic [PW-1:0] rd1;                // Entry after the oldest.
    logic push;                        // Request accepted this cycle.
    logic pop1;                        // One entry leaves.
    logic pop2;                        // Two merged entries leave.
    logic merge;                       // Oldest two writes may merge.
    logic wbeat_reg;                   // Second beat of a size-two write pending.

    // ------------------------------------------------------------------
    // Issue state
    // ------------------------------------------------------------------
    shr_state_t st_reg;                // Issue state.
    logic [SIZE_W-1:0] beats_reg;      // Beats of the issued burst.
    logic [SIZE_W-1:0] beat_reg;       // Beats already sent.
    logic iss_wr_reg;                  // Issued burst is a write.
    logic [DW-1:0] d1_reg;             // Second write beat.
    logic [BE_W-1:0] be1_reg;          // Second beat enables.

    // Full queue refuses the request; the user holds it meanwhile.
    assign local_ready = (count_reg != DEPTH[PW:0]); // [R04] [R03] [R05]
    assign push = (local_read_req || local_write_req) && local_ready; // [R01] [R02]
    assign rd1 = rd_ptr_reg + 1'b1;

    // Merge only when the pair fits one aligned burst; an odd start column
    // is left alone so its neighbour becomes a further burst.
    assign merge = (count_reg >= 2) && q_wr[rd_ptr_reg] && q_wr[rd1]
        && (q_bank[rd1] == q_bank[rd_ptr_reg]) && (q_row[rd1] == q_row[rd_ptr_reg])
        && (q_col[rd1] == q_col[rd_ptr_reg] + 1'b1)
        && !q_col[rd_ptr_reg][0]; // [R18] [R16]
    assign pop1 = (st_reg == SHR_IDLE) && (count_reg != '0) && !merge;
    assign pop2 = (st_reg == SHR_IDLE) && merge;

    // Each accepted beat of a write is its own entry; the held address of
    // a size-two write is advanced by one for the second beat.
    always_ff @(posedge clk) begin
        if (push) begin
            q_wr[wr_ptr_reg] <= local_write_req;
            q_bank[wr_ptr_reg] <= local_bank;
            q_row[wr_ptr_reg] <= local_row;
            q_col[wr_ptr_reg] <= local_col + {{(COL_W-1){1'b0}}, wbeat_reg}; // [R17]
            q_size[wr_ptr_reg] <= local_write_req ? SIZE_W'(1) : local_size;
            q_data[wr_ptr_reg] <= local_wdata;
            q_be[wr_ptr_reg] <= local_be;
        end
    end

    // Tracks the first beat of a size-two write so it needs two accepts.
    always_ff @(posedge clk) begin
        if (rst) begin
            wbeat_reg <= 1'b0;
        end else if (push && local_write_req) begin
            wbeat_reg <= (local_size == SIZE_W'(2)) && !wbeat_reg; // [R17]
        end
    end

    // Queue pointers and occupancy.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            rd_ptr_reg <= rd_ptr_reg + {{(PW-1){1'b0}}, pop1} + (pop2 ? PW'(2) : PW'(0));
            count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop1}
                - (pop2 ? (PW+1)'(2) : (PW+1)'(0));
        end
    end

    // Issue sequence: command cycle, then one transfer cycle per beat.
    // Entries leave the queue in order, so reads return in order too.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= SHR_IDLE;
            beats_reg <= '0;
            beat_reg <= '0;
            iss_wr_reg <= 1'b0;
            d1_reg <= '0;
            be1_reg <= '0;
            afi.cmd_valid <= 1'b0;
            afi.cmd_wr <= 1'b0;
            afi.bank <= '0;
            afi.row <= '0;
            afi.col <= '0;
            afi.wdata <= '0;
            afi.dm <= '0;
            afi.wdata_valid <= 1'b0;
            afi.dqs_burst <= 1'b0;
            afi.doing_rd <= 1'b0;
        end else begin
            unique case (st_reg)
                SHR_IDLE: begin
                    if (count_reg != '0) begin
                        st_reg <= SHR_CMD;
                        afi.cmd_valid <= 1'b1; // [R07] [R19]
                        afi.cmd_wr <= q_wr[rd_ptr_reg];
                        afi.bank <= q_bank[rd_ptr_reg];
                        afi.row <= q_row[rd_ptr_reg];
                        afi.col <= {q_col[rd_ptr_reg], {COL_SHIFT{1'b0}}}; // [R06]
                        afi.dqs_burst <= q_wr[rd_ptr_reg]; // [R09]
                        iss_wr_reg <= q_wr[rd_ptr_reg];
                        beats_reg <= merge ? SIZE_W'(2) : q_size[rd_ptr_reg]; // [R18]
                        afi.wdata <= q_data[rd_ptr_reg];
                        afi.dm <= ~q_be[rd_ptr_reg];
                        d1_reg <= q_data[rd1];
                        be1_reg <= q_be[rd1];
                    end
                end
                SHR_CMD: begin
                    st_reg <= SHR_XFER;
                    afi.cmd_valid <= 1'b0;
                    afi.wdata_valid <= iss_wr_reg; // [R08]
                    afi.doing_rd <= !iss_wr_reg; // [R10]
                    beat_reg <= SIZE_W'(1);
                end
                SHR_XFER: begin
                    if (beat_reg == beats_reg) begin
                        st_reg <= SHR_IDLE;
                        afi.wdata_valid <= 1'b0;
                        afi.doing_rd <= 1'b0;
                        afi.dqs_burst <= 1'b0; // [R09]
                    end else begin
                        beat_reg <= beat_reg + 1'b1;
                        afi.wdata <= d1_reg; // [R08]
                        afi.dm <= ~be1_reg;
                    end
                end
                default: begin
                    st_reg <= SHR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read return with optional ECC latency
    // ------------------------------------------------------------------
    // Without ECC the return is a straight pass; this trades the
    // registered-output style for the zero-delay behaviour required.
    generate
        if (ECC_LAT == 0) begin : g_noecc
            assign local_rdata_valid = afi.rdata_valid; // [R14]
            assign local_rdata = afi.rdata;
        end else begin : g_ecc
            logic v_pipe [ECC_LAT];    // Valid delay stages.
            logic [DW-1:0] d_pipe [ECC_LAT]; // Data delay stages.
            // Shift read words through the ECC delay.
            always_ff @(posedge clk) begin
                if (rst) begin
                    for (int i = 0; i < ECC_LAT; i++) begin
                        v_pipe[i] <= 1'b0;
                        d_pipe[i] <= '0;
                    end
                end else begin
                    v_pipe[0] <= afi.rdata_valid; // [R14]
                    d_pipe[0] <= afi.rdata;
                    for (int i = 1; i < ECC_LAT; i++) begin
                        v_pipe[i] <= v_pipe[i-1];
                        d_pipe[i] <= d_pipe[i-1];
                    end
                end
            end
            assign local_rdata_valid = v_pipe[ECC_LAT-1];
            assign local_rdata = d_pipe[ECC_LAT-1];
        end
    endgenerate

endmodule // shr_ctrl

// ===== rtl/shr_phy.sv
/*
 * PHY end: forwards commands and write data to memory, captures and returns reads.
 * Assumes the memory side returns words in read order on mem_rdata_valid.
 */
`timescale 1ns/1ps
module shr_phy import shr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    shr_afi_if.phy afi,
    // Memory side
    output logic mem_cmd_valid,
    output logic mem_cmd_wr,
    output logic [BANK_W-1:0] mem_bank,
    output logic [ROW_W-1:0] mem_row,
    output logic [MCOL_W-1:0] mem_col,
    output logic [DW-1:0] mem_wdata,
    output logic [BE_W-1:0] mem_dm,
    output logic mem_wdata_valid,
    output logic mem_dqs_toggle,
    input wire logic [DW-1:0] mem_rdata,
    input wire logic mem_rdata_valid
);

    // ------------------------------------------------------------------
    // Capture window and resync pipeline
    // ------------------------------------------------------------------
    logic [3:0] expect_reg;            // Read words still expected.
    logic cap_en;                      // Capture registers enabled.
    logic [RESYNC_STAGES-1:0] v_pipe;  // Valid through resync stages.
    logic [DW-1:0] d_pipe [RESYNC_STAGES]; // Data through resync stages.

    assign cap_en = (expect_reg != 4'h0) || afi.doing_rd;

    // Command and write data go to memory one cycle after the controller.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_cmd_valid <= 1'b0;
            mem_cmd_wr <= 1'b0;
            mem_bank <= '0;
            mem_row <= '0;
            mem_col <= '0;
            mem_wdata <= '0;
            mem_dm <= '0;
            mem_wdata_valid <= 1'b0;
        end else begin
            mem_cmd_valid <= afi.cmd_valid; // [R12] [R15]
            mem_cmd_wr <= afi.cmd_wr;
            mem_bank <= afi.bank;
            mem_row <= afi.row;
            mem_col <= afi.col;
            mem_wdata <= afi.wdata; // [R15]
            mem_dm <= afi.dm;
            mem_wdata_valid <= afi.wdata_valid;
        end
    end

    // The strobe toggles only inside the burst window.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_dqs_toggle <= 1'b0;
        end else if (afi.dqs_burst) begin
            mem_dqs_toggle <= ~mem_dqs_toggle; // [R15]
        end
    end

    // Each doing_rd cycle opens one word of capture; each capture closes one.
    always_ff @(posedge clk) begin
        if (rst) begin
            expect_reg <= 4'h0;
        end else begin
            expect_reg <= expect_reg + {3'h0, afi.doing_rd}
                - {3'h0, mem_rdata_valid && cap_en}; // [R11]
        end
    end

    // Captured words pass resync stages before returning to the controller.
    always_ff @(posedge clk) begin
        if (rst) begin
            v_pipe <= '0;
            for (int i = 0; i < RESYNC_STAGES; i++) begin
                d_pipe[i] <= '0;
            end
        end else begin
            v_pipe[0] <= mem_rdata_valid && cap_en; // [R11] [R12]
            d_pipe[0] <= mem_rdata;
            for (int i = 1; i < RESYNC_STAGES; i++) begin
                v_pipe[i] <= v_pipe[i-1];
                d_pipe[i] <= d_pipe[i-1];
            end
        end
    end

    assign afi.rdata_valid = v_pipe[RESYNC_STAGES-1]; // [R13]
    assign afi.rdata = d_pipe[RESYNC_STAGES-1];

endmodule // shr_phy

// ===== test/shr_monitor.sv
/*
 * Checker for the controller-to-PHY connection of the half-rate request path.
 * Assumes one clock for both ends and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module shr_monitor import shr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command group
    input wire logic cmd_valid,
    input wire logic cmd_wr,
    input wire logic [MCOL_W-1:0] col,
    // Data windows
    input wire logic wdata_valid,
    input wire logic dqs_burst,
    input wire logic doing_rd
);
    // ------------------------------------------------------------------
    // Timing relations on the PHY connection
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Each burst owns at least three cycles, so commands never crowd.
    a_cmd_spacing: assert property (
        cmd_valid |=> !cmd_valid [*2]) else $error("command strobe too close");
    a_col_shifted: assert property (
        cmd_valid |-> col[COL_SHIFT-1:0] == '0) else $error("column not shifted");
    a_wr_data_follows: assert property (
        cmd_valid && cmd_wr |=> wdata_valid) else $error("write data late");
    a_wr_data_len: assert property (
        $rose(wdata_valid) |-> ##2 !wdata_valid) else $error("write data too long");
    a_burst_covers: assert property (
        wdata_valid |-> dqs_burst) else $error("data outside strobe burst");
    a_burst_starts: assert property (
        cmd_valid && cmd_wr |-> dqs_burst ##1 dqs_burst) else $error("strobe burst late");
    a_burst_ends: assert property (
        $fell(wdata_valid) |-> !dqs_burst) else $error("strobe burst overrun");
    a_split_odd: assert property (
        cmd_valid && cmd_wr && col[COL_SHIFT] |=> wdata_valid ##1 !wdata_valid)
        else $error("odd write start merged");
    a_rd_window: assert property (
        cmd_valid && !cmd_wr |=> doing_rd && !wdata_valid) else $error("read window late");
    a_rd_len: assert property (
        $rose(doing_rd) |-> ##2 !doing_rd) else $error("read window too long");
endmodule // shr_monitor

// ===== test/testbench.sv
/*
 * Self-checking bench: controller and PHY joined, bench drives the local side
 * and acts as memory behind the PHY. Assumes a 100 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
    import shr_pkg::*;
    localparam int LAT = 3; // Longest ECC return delay, to stress the pipe.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic local_read_req = 1'b0;
    logic local_write_req = 1'b0;
    logic [SIZE_W-1:0] local_size = '0;
    logic [BANK_W-1:0] local_bank = '0;
    logic [ROW_W-1:0] local_row = '0;
    logic [COL_W-1:0] local_col = '0;
    logic [DW-1:0] local_wdata = '0;
    logic [BE_W-1:0] local_be = '0;
    logic local_ready, local_rdata_valid, mem_cmd_valid, mem_cmd_wr, mem_wdata_valid;
    logic [DW-1:0] local_rdata, mem_wdata;
    logic [BANK_W-1:0] mem_bank;
    logic [ROW_W-1:0] mem_row;
    logic [MCOL_W-1:0] mem_col;
    logic [BE_W-1:0] mem_dm;
    logic [DW-1:0] mem_rdata = '0;
    logic mem_rdata_valid = 1'b0;
    int refused = 0; // Cycles in which a presented request was refused.
    int refused_before = 0; // Refusals counted before the back-pressure test.
    logic mem_dqs_toggle; // Strobe toggle seen on the memory side.
    logic dqs_exp = 1'b0; // Strobe level expected at the next edge.
    logic [LAT-1:0] vpipe = '0; // Delayed copy of the PHY read-valid.
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int wr_key, rd_key, wr_beat, rd_beat;
    logic [DW-1:0] ref_mem [int]; // Expected memory contents.
    logic [DW-1:0] phy_mem [int]; // Memory behind the PHY.
    logic [DW-1:0] exp_q [$];
    logic [DW-1:0] ret_q [$];

    shr_afi_if afi ();
    shr_ctrl #(.DEPTH(CMDQ_DEPTH), .ECC_LAT(LAT)) u_shr_ctrl (.clk(clk), .rst(rst),
        .local_read_req(local_read_req), .local_write_req(local_write_req),
        .local_size(local_size), .local_bank(local_bank), .local_row(local_row),
        .local_col(local_col), .local_wdata(local_wdata), .local_be(local_be),
        .local_ready(local_ready), .local_rdata(local_rdata),
        .local_rdata_valid(local_rdata_valid), .afi(afi.ctrl));
    shr_phy u_shr_phy (.clk(clk), .rst(rst), .afi(afi.phy), .mem_cmd_valid(mem_cmd_valid),
        .mem_cmd_wr(mem_cmd_wr), .mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
        .mem_wdata(mem_wdata), .mem_dm(mem_dm), .mem_wdata_valid(mem_wdata_valid),
        .mem_dqs_toggle(mem_dqs_toggle), .mem_rdata(mem_rdata),
        .mem_rdata_valid(mem_rdata_valid));
    shr_monitor u_shr_monitor (.clk(clk), .rst(rst), .cmd_valid(afi.cmd_valid),
        .cmd_wr(afi.cmd_wr), .col(afi.col), .wdata_valid(afi.wdata_valid),
        .dqs_burst(afi.dqs_burst), .doing_rd(afi.doing_rd));

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers for expected values
    // ------------------------------------------------------------------
    function automatic int key(input int b, input int r, input int c);
        return (b * 8192 + r) * 1024 + c;
    endfunction
    // Unwritten words read back as a pattern of their address.
    function automatic logic [DW-1:0] look(ref logic [DW-1:0] m [int], input int k);
        return m.exists(k) ? m[k] : DW'(k) * 32'h9E37_79B1;
    endfunction
    function automatic logic [DW-1:0] put(input logic [DW-1:0] o, input logic [DW-1:0] d,
                                          input logic [BE_W-1:0] en);
        for (int i = 0; i < BE_W; i++) if (en[i]) o[i*8 +: 8] = d[i*8 +: 8];
        return o;
    endfunction

    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One request; a size-two write is two accepted beats at the same address.
    task automatic req(input logic wr, input int sz, input int b, input int r, input int c);
        logic ok;
        for (int beat = 0; beat < (wr ? sz : 1); beat++) begin
            #1;
            local_write_req = wr;
            local_read_req = !wr;
            local_size = SIZE_W'(sz);
            local_bank = BANK_W'(b);
            local_row = ROW_W'(r);
            local_col = COL_W'(c);
            local_wdata = $urandom;
            local_be = BE_W'($urandom);
            ok = 1'b0;
            // Held unchanged while refused.
            for (int t = 0; t < 60 && !ok; t++) begin
                #4 ok = local_ready;
                @(posedge clk);
            end
            check("request taken", ok, 1'b1);
            if (wr) begin
                ref_mem[key(b, r, c + beat)] = put(look(ref_mem, key(b, r, c + beat)),
                                                   local_wdata, local_be);
            end else begin
                for (int i = 0; i < sz; i++) exp_q.push_back(look(ref_mem, key(b, r, c + i)));
            end
        end
    endtask

    // Release requests and wait for all reads to come home.
    task automatic drain(input string name);
        #1;
        local_read_req = 1'b0;
        local_write_req = 1'b0;
        for (int t = 0; t < 300 && exp_q.size() > 0; t++) @(posedge clk);
        repeat (4) @(posedge clk);
        check("reads outstanding", DW'(exp_q.size()), '0);
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------------
    // Memory behind the PHY: stores write beats, returns one word per
    // read-window cycle on the following cycle.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (mem_cmd_valid) begin
            check("memory column low bits", DW'(mem_col[1:0]), '0);
            wr_beat = mem_cmd_wr ? 0 : wr_beat;
            rd_beat = mem_cmd_wr ? rd_beat : 0;
            if (mem_cmd_wr) wr_key = key(mem_bank, mem_row, int'(mem_col >> 2));
            else rd_key = key(mem_bank, mem_row, int'(mem_col >> 2));
        end
        if (mem_wdata_valid) begin
            phy_mem[wr_key + wr_beat] = put(look(phy_mem, wr_key + wr_beat), mem_wdata, ~mem_dm);
            wr_beat++;
        end
        if (afi.doing_rd) begin
            ret_q.push_back(look(phy_mem, rd_key + rd_beat));
            rd_beat++;
        end
        // The memory strobe must flip after every cycle of the burst window.
        if (!rst) check("strobe toggle", mem_dqs_toggle, dqs_exp);
        dqs_exp = rst ? 1'b0 : mem_dqs_toggle ^ afi.dqs_burst;
        #1;
        mem_rdata_valid = ret_q.size() > 0;
        mem_rdata = (ret_q.size() > 0) ? ret_q.pop_front() : ~mem_rdata;
    end

    // Read return: delay from the PHY valid, data in request order.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
        if (!rst && (local_write_req || local_read_req) && local_ready === 1'b0) refused++;
        if (!rst && (local_rdata_valid !== 1'b0 || vpipe[LAT-1])) begin
            check("read valid delay", local_rdata_valid, vpipe[LAT-1]);
        end
        if (!rst && local_rdata_valid === 1'b1) begin
            check("read data", local_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
        vpipe = rst ? '0 : {vpipe[LAT-2:0], afi.rdata_valid};
    end

    initial begin
        void'($urandom(32'hA488));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        #3;
        check("ready after reset", local_ready, 1'b1);
        check("read valid after reset", local_rdata_valid, 1'b0);
        @(posedge clk);
        $display("test reset done");
        // Merge, split, aligned pair, then read everything back.
        req(1'b1, 1, 0, 0, 0);
        req(1'b1, 1, 0, 0, 1);
        req(1'b1, 2, 0, 0, 1);
        req(1'b1, 2, 0, 0, 4);
        for (int c = 0; c < 6; c++) req(1'b0, 1 + c % 2, 0, 0, c);
        drain("corners");
        // Twelve unmergeable writes back to back, enough for the queue to refuse.
        // Only refusals caused by this test count, not those of the corners.
        refused_before = refused;
        for (int i = 0; i < 12; i++) req(1'b1, 1, 1, 2, 2 * ($urandom % 8) + 1);
        check("queue refused", refused > refused_before, 1'b1);
        for (int c = 1; c < 16; c += 2) req(1'b0, 1, 1, 2, c);
        drain("back pressure");
        for (int i = 0; i < 60; i++) begin
            req(1'(($urandom % 2)), 1 + $urandom % 2, $urandom % 2, $urandom % 2,
                $urandom % 16);
        end
        drain("random");
        conclude();
    end
endmodule // testbench
